// [inc/qlp_pkg.sv]
// Purpose: Shared constants for the quad-link panel host controller.
// Assumes: 200 MHz system clock, four links, 10 bits per colour.
// Notes:   How it works list below; counts derive from times.
//
// How it works
// [R01] Each link carries exactly 480 active pixel clocks per line.
// [R02] Horizontal blanking stays within 40 to 200 clocks, 70 typical.
// [R03] Every frame carries exactly 1080 active lines.
// [R04] Vertical blanking 20..86 lines (NTSC) or 228..300 lines (PAL).
// [R05] Pixel clock stays between 66.97 and 78.00 MHz, 74.25 typical.
// [R06] Frame rate 108..122 Hz for NTSC, 95..104 Hz for PAL.
// [R07] Panel ignores sync lines and uses data enable alone.
// [R08] With spread spectrum, raise the lowest clock above the minimum.
// [R09] Spread rate at 50..100 kHz modulation at most 7 - 0.06*fmod.
// [R10] Avoid spread-spectrum modulation below 30 kHz.
// [R11] Timing counts are derived from the pixel clock actually used.
// [R12] Each colour is unsigned 10 bits, zero black, larger brighter.
// [R13] No signals or control lines before the logic supply is on.
// [R14] Keep 400 ms before backlight on and 200 ms after backlight off.
// [R15] After supply off wait at least 1.0 s before switching on again.
// [R16] Signals are removed no later than the supply goes off.
// [R17] Interface signals never float in invalid periods.
// [R18] All data lines are driven low while the logic supply is off.
// [R19] PWM duty held within 5% to 100% during backlight shutdown.
// [R20] Format select high picks JEIDA, low picks VESA mapping.
// [R21] No-signal input high shows test pattern, low shows black.
// [R22] PWM input high means backlight on; open means full duty.
// [R23] Data enable high only on active pixels of active lines.
// [R24] All four links share one timing and stay aligned.
package qlp_pkg;

    // Link geometry
    localparam int LINKS = 32'h4;
    localparam int PIX_W = 32'h1E;               // 30 bits RGB per link
    localparam int BUS_W = LINKS * PIX_W;

    // Line and frame geometry
    localparam logic [9:0]  H_ACTIVE    = 10'h1E0; // 480
    localparam int          H_BLANK_MIN = 32'h28;  // 40
    localparam int          H_BLANK_TYP = 32'h46;  // 70
    localparam int          H_BLANK_MAX = 32'hC8;  // 200
    localparam logic [10:0] V_ACTIVE    = 11'h438; // 1080
    localparam int          VBN_MIN     = 32'h14;  // 20
    localparam int          VBN_TYP     = 32'h2D;  // 45
    localparam int          VBN_MAX     = 32'h56;  // 86
    localparam int          VBP_MIN     = 32'hE4;  // 228
    localparam int          VBP_TYP     = 32'h10E; // 270
    localparam int          VBP_MAX     = 32'h12C; // 300

    // Pixel clock synthesis: 200 MHz * 594/800 toggles, two per period = 74.25 MHz
    localparam int          ACC_W    = 32'hA;
    localparam logic [10:0] ACC_STEP = 11'h252;    // 594
    localparam logic [10:0] ACC_MOD  = 11'h320;    // 800

    // Sequencing times in ms and the clock rate
    localparam int CLK_MHZ   = 32'hC8;             // 200
    localparam int T_RISE_MS = 32'h14;             // 20, supply rise
    localparam int T3_MS     = 32'h190;            // 400
    localparam int T4_MS     = 32'hC8;             // 200
    localparam int T5_MS     = 32'h3E8;            // 1000 = 1.0 s
    localparam int TMR_W     = 32'h1C;

    // Backlight dimming
    localparam int         PWM_W       = 32'h8;
    localparam int         PWM_MIN_PCT = 32'h5;
    localparam logic [7:0] PWM_MIN     =
        8'((PWM_MIN_PCT * 256 + 99) / 100);       // Rounded up

    // Minimum-time conversion, at least one cycle
    function automatic int ms_to_cyc(input int ms);
        int c;
        c = ms * CLK_MHZ * 1000;
        return (c < 1) ? 1 : c;
    endfunction : ms_to_cyc

    // Power sequencer states, Gray from PW_OFF through PW_COOL; PW_COOL back to PW_OFF flips two bits
    typedef enum logic [2:0] {
        PW_OFF   = 3'h0,
        PW_RISE  = 3'h1,
        PW_SIG   = 3'h3,
        PW_RUN   = 3'h2,
        PW_BLDN  = 3'h6,
        PW_SIGDN = 3'h7,
        PW_COOL  = 3'h5
    } qlp_pwr_e;

endpackage : qlp_pkg

// [inc/qlp_stream_if.sv]
// Purpose: Valid/ready carrier between the controller's own modules.
// Assumes: One source, one sink, same clock.
// Notes:   Width is a parameter.
`timescale 1ns/1ps
`default_nettype none
interface qlp_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : qlp_stream_if
`default_nettype wire

// [hdl/qlp_fifo.sv]
// Purpose: Pixel word FIFO between user stream and line timing.
// Assumes: DEPTH is a power of two; push and pop on one clock.
// Notes:   Ready is registered so back-pressure is a clean flop.
`timescale 1ns/1ps
`default_nettype none
module qlp_fifo #(
    parameter int W     = 120,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic clock_i,
    input  wire logic rst_i,
    // Streams
    qlp_stream_if.snk wr,
    qlp_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("qlp_fifo: DEPTH must be a power of two");
    end

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]   cnt_q, cnt_d;
    logic          rdy_q, rdy_d;
    logic          push, pop;

    // Handshakes and next pointers
    always_comb begin
        push  = wr.valid && rdy_q;
        pop   = rd.ready && (cnt_q != '0);
        wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = AW'(0) + cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        rdy_d = (cnt_d < (AW+1)'(DEPTH));
    end

    // State registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    // Storage
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wp_q] <= wr.data;
        end
    end

    assign wr.ready = rdy_q;
    assign rd.valid = (cnt_q != '0);
    assign rd.data  = mem_q[rp_q];

endmodule : qlp_fifo
`default_nettype wire

// [hdl/qlp_host.sv]
// Purpose: Host that powers, times and feeds a quad-link video panel.
// Assumes: 200 MHz clock; pixel clock made by a phase accumulator.
// Notes:   Data enable only timing; sync lines are not produced.
`timescale 1ns/1ps
`default_nettype none
module qlp_host #(
    parameter int H_BLANK      = qlp_pkg::H_BLANK_TYP,
    parameter int V_BLANK_NTSC = qlp_pkg::VBN_TYP,
    parameter int V_BLANK_PAL  = qlp_pkg::VBP_TYP,
    parameter int FIFO_DEPTH   = 16,
    parameter int T_RISE_CYC   = qlp_pkg::ms_to_cyc(qlp_pkg::T_RISE_MS),
    parameter int T3_CYC       = qlp_pkg::ms_to_cyc(qlp_pkg::T3_MS),
    parameter int T4_CYC       = qlp_pkg::ms_to_cyc(qlp_pkg::T4_MS),
    parameter int T5_CYC       = qlp_pkg::ms_to_cyc(qlp_pkg::T5_MS)
) (
    // Clock and reset
    input  wire logic                       clock_i,
    input  wire logic                       rst_i,
    // User control
    input  wire logic                       power_req_i,
    input  wire logic                       rate_pal_i,
    input  wire logic                       fmt_jeida_i,
    input  wire logic                       test_pattern_i,
    input  wire logic [qlp_pkg::PWM_W-1:0]  pwm_duty_i,
    // User pixel stream
    input  wire logic                       pix_valid_i,
    input  wire logic [qlp_pkg::BUS_W-1:0]  pix_data_i,
    output logic                            pix_ready_o,
    // Status
    output logic                            video_on_o,
    output logic                            underrun_o,
    output logic                            power_idle_o,
    // Panel pins
    output logic                            panel_logic_supply_o,
    output logic                            pix_clk_o,
    output logic                            de_o,
    output logic [qlp_pkg::BUS_W-1:0]       pix_data_o,
    output logic                            fmt_jeida_o,
    output logic                            auto_test_pattern_o,
    output logic                            backlight_on_ctl_o,
    output logic                            backlight_pwm_dim_in_o
);
    import qlp_pkg::*;

    localparam logic [9:0]  H_TOT  = 10'(H_ACTIVE + H_BLANK);
    localparam logic [10:0] VT_NT  = 11'(V_ACTIVE + V_BLANK_NTSC);
    localparam logic [10:0] VT_PAL = 11'(V_ACTIVE + V_BLANK_PAL);

    ////////////////////////////////////////////////////////////////////
    // Elaboration checks
    if (H_BLANK < H_BLANK_MIN || H_BLANK > H_BLANK_MAX) begin : g_bad_h
        $error("qlp_host: H_BLANK out of range"); // see [R02]
    end
    if (V_BLANK_NTSC < VBN_MIN || V_BLANK_NTSC > VBN_MAX ||
        V_BLANK_PAL < VBP_MIN || V_BLANK_PAL > VBP_MAX) begin : g_bad_v
        $error("qlp_host: vertical blanking out of range"); // see [R04]
    end
    if (T_RISE_CYC < 1 || T3_CYC < 1 || T4_CYC < 1 || T5_CYC < 1 ||
        T5_CYC >= (1 << TMR_W)) begin : g_bad_t
        $error("qlp_host: sequencing count out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // Pixel FIFO
    qlp_stream_if #(.W(BUS_W)) in_s ();
    qlp_stream_if #(.W(BUS_W)) out_s ();

    assign in_s.valid  = pix_valid_i;
    assign in_s.data   = pix_data_i;
    assign pix_ready_o = in_s.ready;

    qlp_fifo #(.W(BUS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .wr      (in_s),
        .rd      (out_s)
    );

    ////////////////////////////////////////////////////////////////////
    // Power sequencer
    qlp_pwr_e          st_q, st_d;
    logic [TMR_W-1:0]  tmr_q, tmr_d;
    logic              pal_q, pal_d;
    logic              sup_q, sup_d;
    logic              bl_q, bl_d;
    logic              fmt_q, fmt_d;
    logic              atp_q, atp_d;
    logic              idle_q, idle_d;
    logic              vid_on;

    // Next state and sequencing outputs
    always_comb begin
        st_d  = st_q;
        pal_d = pal_q;
        tmr_d = (tmr_q == '0) ? tmr_q : TMR_W'(tmr_q - 1'b1);
        unique case (st_q)
            PW_OFF: begin
                if (power_req_i) begin
                    st_d  = PW_RISE;
                    tmr_d = TMR_W'(T_RISE_CYC - 1);
                end
            end
            PW_RISE: begin
                if (!power_req_i) begin
                    st_d = PW_SIGDN;
                end else if (tmr_q == '0) begin
                    st_d  = PW_SIG;                // see [R13]
                    pal_d = rate_pal_i;
                    tmr_d = TMR_W'(T3_CYC - 1);
                end
            end
            PW_SIG: begin
                if (!power_req_i) begin
                    st_d = PW_SIGDN;
                end else if (tmr_q == '0) begin
                    st_d = PW_RUN;                 // see [R14]
                end
            end
            PW_RUN: begin
                if (!power_req_i) begin
                    st_d  = PW_BLDN;
                    tmr_d = TMR_W'(T4_CYC - 1);
                end
            end
            PW_BLDN: begin
                if (tmr_q == '0) begin
                    st_d = PW_SIGDN;               // see [R14]
                end
            end
            PW_SIGDN: begin
                st_d  = PW_COOL;                   // see [R16]
                tmr_d = TMR_W'(T5_CYC - 1);
            end
            PW_COOL: begin
                if (tmr_q == '0) begin
                    st_d = PW_OFF;                 // see [R15]
                end
            end
            default: begin
                st_d = PW_OFF;
            end
        endcase
        sup_d  = (st_d != PW_OFF) && (st_d != PW_COOL);
        bl_d   = (st_d == PW_RUN);
        fmt_d  = sup_d && fmt_jeida_i;             // see [R20]
        atp_d  = sup_d && test_pattern_i;          // see [R21]
        idle_d = (st_d == PW_OFF);
    end

    // Sequencer registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_q   <= PW_OFF;
            tmr_q  <= '0;
            pal_q  <= 1'b0;
            sup_q  <= 1'b0;
            bl_q   <= 1'b0;
            fmt_q  <= 1'b0;
            atp_q  <= 1'b0;
            idle_q <= 1'b1;
        end else begin
            st_q   <= st_d;
            tmr_q  <= tmr_d;
            pal_q  <= pal_d;
            sup_q  <= sup_d;
            bl_q   <= bl_d;
            fmt_q  <= fmt_d;
            atp_q  <= atp_d;
            idle_q <= idle_d;
        end
    end

    assign vid_on = (st_q == PW_SIG) || (st_q == PW_RUN) ||
                    (st_q == PW_BLDN);

    ////////////////////////////////////////////////////////////////////
    // Pixel clock and line/frame timing
    logic [ACC_W-1:0] acc_q, acc_d;
    logic             pclk_q, pclk_d;
    logic [9:0]       h_q, h_d;
    logic [10:0]      v_q, v_d;
    logic             de_q, de_d;
    logic [BUS_W-1:0] dat_q, dat_d;
    logic             urun_q, urun_d;
    logic             von_q;
    logic             tick;
    logic             active;
    logic [10:0]      acc_sum;
    logic [10:0]      v_tot;

    // Next pixel state, one tick per rising pixel clock
    always_comb begin
        acc_d   = acc_q;
        pclk_d  = pclk_q;
        h_d     = h_q;
        v_d     = v_q;
        de_d    = de_q;
        dat_d   = dat_q;
        urun_d  = 1'b0;
        tick    = 1'b0;
        active  = (h_q < H_ACTIVE) && (v_q < V_ACTIVE);
        acc_sum = 11'(acc_q) + ACC_STEP;   // No spread, see [R08] [R09] [R10]
        v_tot   = pal_q ? VT_PAL : VT_NT;          // see [R04] [R06]
        if (!vid_on) begin
            acc_d  = '0;                           // see [R18]
            pclk_d = 1'b0;
            h_d    = '0;
            v_d    = '0;
            de_d   = 1'b0;
            dat_d  = '0;
        end else begin
            if (acc_sum >= ACC_MOD) begin          // see [R05]
                acc_d  = ACC_W'(acc_sum - ACC_MOD);
                pclk_d = ~pclk_q;
                tick   = ~pclk_q;
            end else begin
                acc_d = ACC_W'(acc_sum);
            end
            if (tick) begin
                // One data enable and one word for all links
                de_d   = active;                   // see [R23] [R24]
                dat_d  = (active && out_s.valid) ? out_s.data : '0;
                urun_d = active && !out_s.valid;   // see [R17]
                if (h_q == H_TOT - 10'h001) begin  // see [R01] [R02]
                    h_d = '0;
                    v_d = (v_q == v_tot - 11'h001) ? '0 :
                          11'(v_q + 1'b1);         // see [R03] [R11]
                end else begin
                    h_d = 10'(h_q + 1'b1);
                end
            end
        end
    end

    assign out_s.ready = tick && active;

    // Timing registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            acc_q  <= '0;
            pclk_q <= 1'b0;
            h_q    <= '0;
            v_q    <= '0;
            de_q   <= 1'b0;
            dat_q  <= '0;
            urun_q <= 1'b0;
            von_q  <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            pclk_q <= pclk_d;
            h_q    <= h_d;
            v_q    <= v_d;
            de_q   <= de_d;
            dat_q  <= dat_d;
            urun_q <= urun_d;
            von_q  <= vid_on;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Backlight dimming
    logic [PWM_W-1:0] pcnt_q, pcnt_d;
    logic [PWM_W-1:0] duty;
    logic             pwm_q, pwm_d;

    // Duty floor during shutdown, full scale means always high
    always_comb begin
        pcnt_d = PWM_W'(pcnt_q + 1'b1);
        duty   = pwm_duty_i;
        if (st_q == PW_BLDN && pwm_duty_i < PWM_MIN) begin
            duty = PWM_MIN;                        // see [R19]
        end
        pwm_d = ((st_q == PW_RUN) || (st_q == PW_BLDN)) &&
                ((pcnt_q < duty) || (&duty));      // see [R22]
    end

    // Dimming registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pcnt_q <= '0;
            pwm_q  <= 1'b0;
        end else begin
            pcnt_q <= pcnt_d;
            pwm_q  <= pwm_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign panel_logic_supply_o   = sup_q;
    assign pix_clk_o              = pclk_q;
    assign de_o                   = de_q;
    assign pix_data_o             = dat_q;
    assign fmt_jeida_o            = fmt_q;
    assign auto_test_pattern_o    = atp_q;
    assign backlight_on_ctl_o     = bl_q;
    assign backlight_pwm_dim_in_o = pwm_q;
    assign video_on_o             = von_q;
    assign underrun_o             = urun_q;
    assign power_idle_o           = idle_q;

    ////////////////////////////////////////////////////////////////////
    // Checks
    logic [9:0] dew_q, dew_d;

    // Width of the current data enable run in pixel ticks
    always_comb begin
        dew_d = dew_q;
        if (tick || !vid_on) begin
            dew_d = de_d ? 10'(dew_q + 1'b1) : '0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dew_q <= '0;
        end else begin
            dew_q <= dew_d;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    chk_de_width: assert property (de_q && tick && !de_d |-> // see [R01]
        dew_q == H_ACTIVE)
        else $error("data enable run is not 480 pixels");
    chk_line_wrap: assert property (tick && h_q == H_TOT - 10'h001 // see [R02]
        |=> h_q == '0)
        else $error("line did not wrap at line total");
    chk_frame_wrap: assert property ($fell(|v_q) && vid_on // see [R03]
        |-> $past(v_q) == v_tot - 11'h001)
        else $error("frame did not wrap at frame total");
    chk_sig_supply: assert property (de_o || pix_clk_o // see [R13]
        |-> panel_logic_supply_o && $past(panel_logic_supply_o))
        else $error("signal driven without logic supply");
    chk_data_low: assert property (!panel_logic_supply_o // see [R18]
        |-> pix_data_o == '0 && !de_o && !pix_clk_o)
        else $error("data lines high with supply off");
    chk_blank_zero: assert property (!de_o |-> pix_data_o == '0) // see [R17]
        else $error("data not zero outside data enable");
    chk_bl_after: assert property ($rose(backlight_on_ctl_o) // see [R14]
        |-> $past(st_q, 2) == PW_SIG && von_q)
        else $error("backlight on outside sequence");
    chk_pwm_floor: assert property (st_q == PW_BLDN && // see [R19]
        pcnt_q < PWM_MIN |=> backlight_pwm_dim_in_o)
        else $error("dimming below floor during shutdown");
    chk_cool_hold: assert property ($fell(panel_logic_supply_o) // see [R15]
        |-> (!panel_logic_supply_o)[*8])
        else $error("supply back on too soon");

    cov_frame: cover property (vid_on && tick && v_q == v_tot - 11'h001 &&
        h_q == H_TOT - 10'h001);
    cov_bl_on: cover property ($rose(backlight_on_ctl_o));
    cov_down: cover property (st_q == PW_COOL ##1 st_q == PW_OFF);
    cov_urun: cover property (underrun_o);

endmodule : qlp_host
`default_nettype wire

// [verif/qlp_panel_model.sv]
// Purpose: Panel-side model that reads the host's video and control pins.
// Assumes: Pins sampled on the host clock; a tick is a link clock rise with data enable high.
// Notes:   Line and blank lengths come from data enable alone.
`timescale 1ns/1ps
`default_nettype none
module qlp_panel_model (
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    // Panel pins
    input  wire logic         supply_i,
    input  wire logic         pclk_i,
    input  wire logic         de_i,
    input  wire logic [119:0] data_i,
    input  wire logic         fmt_i,
    input  wire logic         pat_i,
    input  wire logic         pwm_i,
    // Observations
    output logic              tick_o,
    output logic [9:0]        act_o,
    output logic [9:0]        blank_o,
    output logic              dirty_o,
    output logic              jeida_o,
    output logic              pattern_o,
    output logic              light_o
);
    logic       pclk_q;
    logic       de_q;
    logic [9:0] run_q;

    ////////////////////////////////////////////////////////////////////
    // Level pins read as they stand; tick from the link clock rise and data enable
    assign jeida_o   = fmt_i;
    assign pattern_o = pat_i;
    assign light_o   = pwm_i;                      // High lit
    assign tick_o    = pclk_i & ~pclk_q & de_i;

    ////////////////////////////////////////////////////////////////////
    // Run lengths of enable, black outside active pixels
    always_ff @(posedge clock_i) begin
        pclk_q <= pclk_i;
        if (rst_i) begin
            de_q    <= 1'b0;
            run_q   <= 10'h0;
            dirty_o <= 1'b0;
        end else begin
            if (!supply_i && (de_i || data_i != '0)) begin
                dirty_o <= 1'b1;
            end
            if (pclk_i && !pclk_q) begin
                de_q  <= de_i;
                run_q <= (de_i != de_q) ? 10'h1 : run_q + 10'h1;
                if (de_i != de_q && de_q) begin
                    act_o <= run_q;
                end
                if (de_i != de_q && !de_q) begin
                    blank_o <= run_q;
                end
                if (!de_i && data_i != '0) begin
                    dirty_o <= 1'b1;
                end
            end
        end
    end
endmodule : qlp_panel_model
`default_nettype wire

// [verif/tb_quad_link_panel_video_timing.sv]
// Purpose: Self-checking bench for the quad-link panel host.
// Assumes: Short sequencing counts; panel model on the pins.
// Notes:   Runs power up, stream, dimming and power down once.
`timescale 1ns/1ps
`default_nettype none
module tb_quad_link_panel_video_timing;
    import qlp_pkg::*;
    localparam int TR = 20, T3 = 200, T4 = 300, T5 = 50;
    logic clock_i = 1'b0, rst_i = 1'b1, power_req_i = 1'b0;
    logic rate_pal_i = 1'b0, fmt_jeida_i = 1'b1, test_pattern_i = 1'b1;
    logic [7:0] pwm_duty_i = 8'h80;
    logic pix_valid_i = 1'b0, pix_ready_o, video_on_o, underrun_o;
    logic [BUS_W-1:0] pix_data_i = '0, pix_data_o;
    logic power_idle_o, panel_logic_supply_o, pix_clk_o, de_o;
    logic fmt_jeida_o, auto_test_pattern_o, backlight_on_ctl_o, pwm_o;
    logic tick, dirty, jeida, pattern, light, ur_seen = 1'b0;
    logic [9:0] act, blank;
    int err_count = 0, checked = 0, cyc = 0;

    qlp_host #(.H_BLANK(40), .T_RISE_CYC(TR), .T3_CYC(T3), .T4_CYC(T4),
        .T5_CYC(T5)) dut (.clock_i(clock_i), .rst_i(rst_i),
        .power_req_i(power_req_i), .rate_pal_i(rate_pal_i),
        .fmt_jeida_i(fmt_jeida_i), .test_pattern_i(test_pattern_i),
        .pwm_duty_i(pwm_duty_i), .pix_valid_i(pix_valid_i),
        .pix_data_i(pix_data_i), .pix_ready_o(pix_ready_o),
        .video_on_o(video_on_o), .underrun_o(underrun_o),
        .power_idle_o(power_idle_o),
        .panel_logic_supply_o(panel_logic_supply_o),
        .pix_clk_o(pix_clk_o), .de_o(de_o), .pix_data_o(pix_data_o),
        .fmt_jeida_o(fmt_jeida_o), .auto_test_pattern_o(auto_test_pattern_o),
        .backlight_on_ctl_o(backlight_on_ctl_o),
        .backlight_pwm_dim_in_o(pwm_o));
    qlp_panel_model panel (.clock_i(clock_i), .rst_i(rst_i),
        .supply_i(panel_logic_supply_o), .pclk_i(pix_clk_o), .de_i(de_o),
        .data_i(pix_data_o), .fmt_i(fmt_jeida_o),
        .pat_i(auto_test_pattern_o), .pwm_i(pwm_o), .tick_o(tick),
        .act_o(act), .blank_o(blank), .dirty_o(dirty), .jeida_o(jeida),
        .pattern_o(pattern), .light_o(light));

    ////////////////////////////////////////////////////////////////////
    // Clock, underrun catcher and hang guard
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (underrun_o === 1'b1) ur_seen <= 1'b1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    // Compare one value, count and report
    task automatic check(input string nm, input logic [119:0] seen,
                         input logic [119:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // Distinct word per push; the last one white on every link
    function automatic logic [119:0] pw(input int i);
        if (i == 15) return {120{1'b1}};
        return {30'(i * 4 + 3), 30'(i * 4 + 2), 30'(i * 4 + 1), 30'(i * 4)};
    endfunction : pw

    function automatic logic pick(input int s);
        case (s)
            0: return panel_logic_supply_o;
            1: return backlight_on_ctl_o;
            default: return power_idle_o;
        endcase
    endfunction : pick

    // Bounded wait for a level, counting edges
    task automatic wait_on(input int s, input logic v, output int n);
        n = 0;
        while (pick(s) !== v && n < 3000) begin
            @(posedge clock_i);
            #1;
            n++;
        end
    endtask : wait_on

    // High cycles of the dimming pin over one 256-cycle period
    task automatic count_light(output int n);
        n = 0;
        repeat (256) begin
            @(posedge clock_i);
            #1;
            n += int'(light);
        end
    endtask : count_light

    // Reset values, then fill the FIFO while the panel is unpowered
    task automatic t_fill();
        int n;
        check("idle", power_idle_o, 1'b1);
        check("supply", panel_logic_supply_o, 1'b0);
        check("pins off", {jeida, pattern, light, de_o}, 4'h0);
        @(posedge clock_i);
        pix_valid_i <= 1'b1;
        pix_data_i  <= pw(0);
        n = 0;
        repeat (40) begin
            @(posedge clock_i);
            if (pix_ready_o === 1'b1) begin
                n++;
                pix_data_i <= pw(n);
            end
        end
        pix_valid_i <= 1'b0;
        check("accepted", 120'(n), 120'h10);
        $display("test fill done");
    endtask : t_fill

    // Power up order, pin pass-through and the first pixels of a line
    task automatic t_up();
        int n, k, g;
        power_req_i <= 1'b1;
        wait_on(0, 1'b1, n);
        k = 0;
        g = 0;
        while (k < 17 && g < 6000) begin
            @(posedge clock_i);
            #1;
            g++;
            if (tick === 1'b1) begin
                check("pixel", pix_data_o, (k < 16) ? pw(k) : '0);
                k++;
            end
        end
        check("pixels", 120'(k), 120'h11);
        check("select", {jeida, pattern, video_on_o}, 3'h7);
        wait_on(1, 1'b1, n);
        check("rise to light", 120'(n + g), 120'(TR + T3));
        repeat (4000) @(posedge clock_i);
        check("active", 120'(act), 120'h1E0);
        check("blank", 120'(blank), 120'h28);
        check("underrun", ur_seen, 1'b1);
        count_light(n);
        check("duty run", 120'(n), 120'h80);
        $display("test up done");
    endtask : t_up

    // Dimming floor, supply off time and refused request in cool down
    task automatic t_down();
        int n;
        @(posedge clock_i);
        pwm_duty_i  <= 8'h00;
        power_req_i <= 1'b0;
        wait_on(1, 1'b0, n);
        repeat (2) @(posedge clock_i);
        power_req_i <= 1'b1;
        count_light(n);
        check("duty floor", 120'(n), 120'(PWM_MIN));
        wait_on(0, 1'b0, n);
        check("pins cut", {jeida, pattern, de_o}, 3'h0);
        wait_on(2, 1'b1, n);
        check("cool", 120'(n), 120'(T5));
        check("black", {dirty, video_on_o}, 2'h0);
        $display("test down done");
    endtask : t_down

    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (3) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        t_fill();
        t_up();
        t_down();
        tally_and_finish();
    end
endmodule : tb_quad_link_panel_video_timing
`default_nettype wire
